/* File: src/ocd_pkg.sv */
// Purpose: Shared constants and types for the display configuration decoder pair
// Assumes: One 20 MHz clock shared by host end and device end
// Notes:   Command codes, field positions and most power-on defaults live here; the checker repeats codes as literals
package ocd_pkg;

	localparam int          CLK_HZ          = 20_000_000;
	localparam int          BYTE_W          = 8;

	// Single-byte command codes and match masks
	localparam logic [7:0] CMD_ALL_ON       = 8'ha4;
	localparam logic [7:0] CMD_REVERSE      = 8'ha6;
	localparam logic [7:0] CMD_DISPLAY      = 8'hae;
	localparam logic [7:0] MASK_BIT0        = 8'hfe;
	localparam logic [7:0] CMD_PAGE         = 8'hb0;
	localparam logic [7:0] MASK_PAGE        = 8'hf8;
	localparam logic [7:0] CMD_SCAN         = 8'hc0;
	localparam logic [7:0] MASK_SCAN        = 8'hf0;
	localparam logic [7:0] CMD_SCAN_DOWN    = 8'hc8;

	// Lead bytes of two-byte commands
	localparam logic [7:0] CMD_MUX          = 8'ha8;
	localparam logic [7:0] CMD_PUMP         = 8'had;
	localparam logic [7:0] CMD_OFFSET       = 8'hd3;
	localparam logic [7:0] CMD_CLOCK        = 8'hd5;
	localparam logic [7:0] CMD_PHASE        = 8'hd9;
	localparam logic [7:0] CMD_PADS         = 8'hda;
	localparam logic [7:0] CMD_DESELECT     = 8'hdb;

	// Data byte forms
	localparam logic [7:0] PUMP_DATA_BASE   = 8'h8a;
	localparam logic [7:0] PADS_DATA_BASE   = 8'h02;
	localparam int          PADS_ALT_BIT    = 4;
	localparam int          SCAN_DIR_BIT    = 3;
	localparam int          MUX_W           = 6;
	localparam int          PAGE_W          = 3;
	localparam int          NIB_W           = 4;

	// Power-on defaults and the deselect saturation level
	localparam logic [5:0] MUX_RST          = 6'h3f;
	localparam logic [5:0] OFFSET_RST       = 6'h00;
	localparam logic [3:0] DIV_RST          = 4'h0;
	localparam logic [3:0] TRIM_RST         = 4'h5;
	localparam logic [3:0] PRECHG_RST       = 4'h2;
	localparam logic [3:0] DISCHG_RST       = 4'h2;
	localparam logic [7:0] DESELECT_RST     = 8'h20;
	localparam logic [7:0] DESELECT_SAT     = 8'h40;
	localparam logic [2:0] PAGE_RST         = 3'h0;

	// Oscillator trim: nominal code and percent per step
	localparam int          TRIM_NOMINAL    = 5;
	localparam int          TRIM_STEP_PCT   = 5;

	typedef enum logic [3:0] {
		OCD_REQ_ALL_ON,
		OCD_REQ_REVERSE,
		OCD_REQ_DISPLAY,
		OCD_REQ_PAGE,
		OCD_REQ_SCAN,
		OCD_REQ_MUX,
		OCD_REQ_PUMP,
		OCD_REQ_OFFSET,
		OCD_REQ_CLOCK,
		OCD_REQ_PHASE,
		OCD_REQ_PADS,
		OCD_REQ_DESELECT,
		OCD_REQ_RAM
	} ocd_req_t;

endpackage

/* File: src/ocd_link_if.sv */
// Purpose: Byte write path between host and decoder
// Assumes: Both ends on clk; one byte per cycle while wr_valid is high
// Notes:   Decoder accepts every offered byte, so there is no ready
`timescale 1ns/1ps
interface ocd_link_if (
	input wire logic clk
);
	logic       wr_valid;
	logic       cmd_data_select;
	logic [7:0] wr_byte;

	modport dev (
		input wr_valid,
		input cmd_data_select,
		input wr_byte
	);

	modport host (
		output wr_valid,
		output cmd_data_select,
		output wr_byte
	);
endinterface

/* File: src/ocd_decoder.sv */
// Purpose: Device end; decodes configuration commands and holds the settings
// Assumes: Host keeps the far-end obligations (pump command only while display off,
//          no zero phase periods)
// Notes:   Data bytes pass to the RAM port even while asleep
`timescale 1ns/1ps

// Summary of operation
// R01 - A4/A5 forces all pixels lit, RAM kept
// R02 - All-on overrides the reverse setting
// R03 - A6/A7 selects normal or inverted pixels
// R04 - A8 plus byte: ratio low six bits plus one
// R05 - AD plus 8A/8B: pump disabled or armed
// R06 - Host issues pump command only while off
// R07 - Display off always means sleep
// R08 - AE/AF switches panel off or on
// R09 - Sleep stops oscillator, pump, drivers float
// R10 - Sleep keeps settings and RAM access
// R11 - B0-B7 loads page address only
// R12 - C0/C8 bit3 sets common scan direction
// R13 - D3 plus byte: six-bit display offset
// R14 - D5 plus byte: low nibble plus one divides
// R15 - D5 high nibble trims oscillator five percent
// R16 - D9 low nibble sets pre-charge period
// R17 - D9 high nibble sets discharge period
// R18 - DA plus 02/12 selects pad layout
// R19 - DB plus byte sets deselect level
// R20 - Commands need select low; next byte is data
// R21 - Reset loads defaults, clears pending state
module ocd_decoder (
	input  wire logic              clk,
	input  wire logic              reset,
	ocd_link_if.dev                link,
	input  wire logic              ram_bit,
	output logic                   pixel_lit_q,
	output logic                   all_on_q,
	output logic                   reverse_q,
	output logic                   display_on_q,
	output logic                   sleep_q,
	output logic                   osc_run_q,
	output logic                   pump_armed_q,
	output logic                   pump_run_q,
	output logic                   ext_supply_q,
	output logic                   drivers_hiz_q,
	output logic [ocd_pkg::MUX_W-1:0]  mux_code_q,
	output logic [ocd_pkg::MUX_W:0]    mux_rows_q,
	output logic [ocd_pkg::PAGE_W-1:0] page_q,
	output logic                   scan_down_q,
	output logic [ocd_pkg::MUX_W-1:0]  offset_q,
	output logic [ocd_pkg::NIB_W-1:0]  clk_div_q,
	output logic [ocd_pkg::NIB_W-1:0]  osc_trim_q,
	output logic signed [7:0]      osc_trim_pct_q,
	output logic                   display_clock_tick_q,
	output logic [ocd_pkg::NIB_W-1:0]  precharge_q,
	output logic [ocd_pkg::NIB_W-1:0]  discharge_q,
	output logic                   pads_alt_q,
	output logic [7:0]             common_deselect_level_q,
	output logic                   deselect_sat_q,
	output logic                   ram_wr_q,
	output logic [7:0]             ram_data_q
);
	import ocd_pkg::*;

	typedef enum logic [2:0] {
		OCD_PEND_NONE,
		OCD_PEND_MUX,
		OCD_PEND_PUMP,
		OCD_PEND_OFFSET,
		OCD_PEND_CLOCK,
		OCD_PEND_PHASE,
		OCD_PEND_PADS,
		OCD_PEND_DESELECT
	} ocd_pend_t;

	ocd_pend_t              pend_q;
	logic                   cmd_wr;
	logic                   data_wr;
	logic                   lead_wr;
	logic [7:0]             b;
	logic [NIB_W-1:0]       tick_cnt_q;

	function automatic logic match(input logic [7:0] v, input logic [7:0] code,
		input logic [7:0] mask);
		match = (v & mask) == (code & mask);
	endfunction

	function automatic logic signed [7:0] trim_pct(input logic [3:0] code);
		trim_pct = 8'(($signed({4'h0, code}) - 8'(TRIM_NOMINAL)) * 8'(TRIM_STEP_PCT));
	endfunction

	assign b       = link.wr_byte;
	assign cmd_wr  = link.wr_valid && !link.cmd_data_select; // R20
	assign data_wr = cmd_wr && (pend_q != OCD_PEND_NONE); // R20
	assign lead_wr = cmd_wr && (pend_q == OCD_PEND_NONE);

	// Pending second-byte tracker
	always_ff @(posedge clk) begin
		if (reset) begin
			pend_q <= OCD_PEND_NONE; // R21
		end else if (data_wr) begin
			pend_q <= OCD_PEND_NONE; // R20
		end else if (lead_wr) begin
			case (b)
				CMD_MUX:      pend_q <= OCD_PEND_MUX;
				CMD_PUMP:     pend_q <= OCD_PEND_PUMP;
				CMD_OFFSET:   pend_q <= OCD_PEND_OFFSET;
				CMD_CLOCK:    pend_q <= OCD_PEND_CLOCK;
				CMD_PHASE:    pend_q <= OCD_PEND_PHASE;
				CMD_PADS:     pend_q <= OCD_PEND_PADS;
				CMD_DESELECT: pend_q <= OCD_PEND_DESELECT;
				default:      pend_q <= OCD_PEND_NONE;
			endcase
		end
	end

	// Single-byte display mode, page address and scan direction commands
	always_ff @(posedge clk) begin
		if (reset) begin
			all_on_q     <= 1'b0; // R21
			reverse_q    <= 1'b0;
			display_on_q <= 1'b0;
			page_q       <= PAGE_RST;
			scan_down_q  <= 1'b0;
		end else if (lead_wr) begin
			if (match(b, CMD_ALL_ON, MASK_BIT0)) begin
				all_on_q <= b[0]; // R01
			end
			if (match(b, CMD_REVERSE, MASK_BIT0)) begin
				reverse_q <= b[0]; // R03
			end
			if (match(b, CMD_DISPLAY, MASK_BIT0)) begin
				display_on_q <= b[0]; // R08
			end
			if (match(b, CMD_PAGE, MASK_PAGE)) begin
				page_q <= b[PAGE_W-1:0]; // R11
			end
			if (match(b, CMD_SCAN, MASK_SCAN)) begin
				scan_down_q <= b[SCAN_DIR_BIT]; // R12
			end
		end
	end

	// Second-byte settings; unused bits dropped where the setting is narrower than the byte
	always_ff @(posedge clk) begin
		if (reset) begin
			mux_code_q              <= MUX_RST; // R21
			pump_armed_q            <= 1'b1;
			offset_q                <= OFFSET_RST;
			clk_div_q               <= DIV_RST;
			osc_trim_q              <= TRIM_RST;
			precharge_q             <= PRECHG_RST;
			discharge_q             <= DISCHG_RST;
			pads_alt_q              <= 1'b1;
			common_deselect_level_q <= DESELECT_RST;
		end else if (data_wr) begin
			case (pend_q)
				OCD_PEND_MUX: begin
					mux_code_q <= b[MUX_W-1:0]; // R04
				end
				OCD_PEND_PUMP: begin
					pump_armed_q <= b[0]; // R05
				end
				OCD_PEND_OFFSET: begin
					offset_q <= b[MUX_W-1:0]; // R13
				end
				OCD_PEND_CLOCK: begin
					clk_div_q  <= b[NIB_W-1:0]; // R14
					osc_trim_q <= b[7:NIB_W]; // R15
				end
				OCD_PEND_PHASE: begin
					precharge_q <= b[NIB_W-1:0]; // R16
					discharge_q <= b[7:NIB_W]; // R17
				end
				OCD_PEND_PADS: begin
					pads_alt_q <= b[PADS_ALT_BIT]; // R18
				end
				OCD_PEND_DESELECT: begin
					common_deselect_level_q <= b; // R19
				end
				default: begin
				end
			endcase
		end
	end

	// Derived views of the held settings
	always_ff @(posedge clk) begin
		if (reset) begin
			mux_rows_q     <= {1'b0, MUX_RST} + 7'h01;
			osc_trim_pct_q <= trim_pct(TRIM_RST);
			deselect_sat_q <= 1'b0;
		end else begin
			mux_rows_q     <= {1'b0, mux_code_q} + 7'h01; // R04
			osc_trim_pct_q <= trim_pct(osc_trim_q); // R15
			deselect_sat_q <= common_deselect_level_q >= DESELECT_SAT; // R19
		end
	end

	// Power state: off is sleep regardless of pump
	always_ff @(posedge clk) begin
		if (reset) begin
			sleep_q       <= 1'b1;
			osc_run_q     <= 1'b0;
			pump_run_q    <= 1'b0;
			ext_supply_q  <= 1'b0;
			drivers_hiz_q <= 1'b1;
		end else begin
			sleep_q       <= !display_on_q; // R07
			osc_run_q     <= display_on_q; // R09
			pump_run_q    <= display_on_q && pump_armed_q; // R07 R09
			ext_supply_q  <= display_on_q && !pump_armed_q; // R07
			drivers_hiz_q <= !display_on_q; // R09
		end
	end

	// Display clock: oscillator stands still while asleep
	always_ff @(posedge clk) begin
		if (reset || !display_on_q) begin
			tick_cnt_q           <= '0; // R09
			display_clock_tick_q <= 1'b0;
		end else if (tick_cnt_q >= clk_div_q) begin
			tick_cnt_q           <= '0; // R14
			display_clock_tick_q <= 1'b1;
		end else begin
			tick_cnt_q           <= tick_cnt_q + 4'h1;
			display_clock_tick_q <= 1'b0;
		end
	end

	// Pixel output; blanked while asleep
	always_ff @(posedge clk) begin
		if (reset) begin
			pixel_lit_q <= 1'b0;
		end else if (!display_on_q) begin
			pixel_lit_q <= 1'b0; // R09
		end else if (all_on_q) begin
			pixel_lit_q <= 1'b1; // R01 R02
		end else begin
			pixel_lit_q <= ram_bit ^ reverse_q; // R03
		end
	end

	// RAM write path stays open in sleep
	always_ff @(posedge clk) begin
		if (reset) begin
			ram_wr_q   <= 1'b0;
			ram_data_q <= 8'h00;
		end else begin
			ram_wr_q <= link.wr_valid && link.cmd_data_select; // R10
			if (link.wr_valid && link.cmd_data_select) begin
				ram_data_q <= b;
			end
		end
	end

endmodule

/* File: src/ocd_host.sv */
// Purpose: Host end; turns configuration requests into command byte sequences
// Assumes: Decoder takes one byte per cycle without stalling
// Notes:   Requests that would break the command protocol are refused
`timescale 1ns/1ps
module ocd_host (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             req_valid,
	input  wire ocd_pkg::ocd_req_t req_kind,
	input  wire logic [7:0]       req_arg,
	output logic                  req_ready_q,
	output logic                  req_refused_q,
	output logic                  display_on_q,
	ocd_link_if.host              link
);
	import ocd_pkg::*;

	typedef enum logic [1:0] {
		OCD_H_IDLE,
		OCD_H_SECOND
	} ocd_hstate_t;

	ocd_hstate_t state_q;
	logic [7:0]  second_q;
	logic        take;
	logic        bad;
	logic        two_byte;
	logic [7:0]  lead;
	logic [7:0]  second;

	assign take = req_valid && req_ready_q;

	// Build the lead and data bytes of a request
	always_comb begin
		lead     = 8'h00;
		second   = 8'h00;
		two_byte = 1'b0;
		bad      = 1'b0;
		case (req_kind)
			OCD_REQ_ALL_ON:   lead = CMD_ALL_ON | {7'h00, req_arg[0]};
			OCD_REQ_REVERSE:  lead = CMD_REVERSE | {7'h00, req_arg[0]};
			OCD_REQ_DISPLAY:  lead = CMD_DISPLAY | {7'h00, req_arg[0]};
			OCD_REQ_PAGE:     lead = CMD_PAGE | {5'h00, req_arg[PAGE_W-1:0]};
			OCD_REQ_SCAN:     lead = req_arg[0] ? CMD_SCAN_DOWN : CMD_SCAN;
			OCD_REQ_MUX: begin
				lead     = CMD_MUX; // R04
				second   = {2'b00, req_arg[MUX_W-1:0]};
				two_byte = 1'b1;
			end
			OCD_REQ_PUMP: begin
				lead     = CMD_PUMP; // R05
				second   = PUMP_DATA_BASE | {7'h00, req_arg[0]};
				two_byte = 1'b1;
				bad      = display_on_q; // R06
			end
			OCD_REQ_OFFSET: begin
				lead     = CMD_OFFSET; // R13
				second   = {2'b00, req_arg[MUX_W-1:0]};
				two_byte = 1'b1;
			end
			OCD_REQ_CLOCK: begin
				lead     = CMD_CLOCK; // R14
				second   = req_arg;
				two_byte = 1'b1;
			end
			OCD_REQ_PHASE: begin
				lead     = CMD_PHASE;
				second   = req_arg;
				two_byte = 1'b1;
				bad      = (req_arg[NIB_W-1:0] == 4'h0) || (req_arg[7:NIB_W] == 4'h0); // R16 R17
			end
			OCD_REQ_PADS: begin
				lead     = CMD_PADS; // R18
				second   = PADS_DATA_BASE | {3'h0, req_arg[PADS_ALT_BIT], 4'h0};
				two_byte = 1'b1;
			end
			OCD_REQ_DESELECT: begin
				lead     = CMD_DESELECT; // R19
				second   = req_arg;
				two_byte = 1'b1;
			end
			OCD_REQ_RAM:      lead = req_arg;
			default:          bad  = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q              <= OCD_H_IDLE;
			second_q             <= 8'h00;
			req_ready_q          <= 1'b1;
			req_refused_q        <= 1'b0;
			display_on_q         <= 1'b0;
			link.wr_valid        <= 1'b0;
			link.cmd_data_select <= 1'b0;
			link.wr_byte         <= 8'h00;
		end else begin
			req_refused_q <= take && bad;
			case (state_q)
				OCD_H_IDLE: begin
					link.wr_valid <= take && !bad;
					if (take && !bad) begin
						link.cmd_data_select <= req_kind == OCD_REQ_RAM;
						link.wr_byte         <= lead;
						second_q             <= second;
						if (req_kind == OCD_REQ_DISPLAY) begin
							display_on_q <= req_arg[0];
						end
						if (two_byte) begin
							state_q     <= OCD_H_SECOND;
							req_ready_q <= 1'b0;
						end
					end
				end
				OCD_H_SECOND: begin
					link.wr_valid        <= 1'b1;
					link.cmd_data_select <= 1'b0;
					link.wr_byte         <= second_q;
					state_q              <= OCD_H_IDLE;
					req_ready_q          <= 1'b1;
				end
				default: begin
					state_q     <= OCD_H_IDLE;
					req_ready_q <= 1'b1;
				end
			endcase
		end
	end

endmodule

/* File: verif/ocd_link_chk.sv */
// Purpose: Protocol and setting checks across the host to decoder byte link
// Assumes: Single clock, synchronous active-high reset
// Notes:   Tracks pending two-byte commands from the wire itself
`timescale 1ns/1ps
module ocd_link_chk (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       wr_valid,
	input wire logic       cmd_data_select,
	input wire logic [7:0] wr_byte,
	input wire logic       all_on_q,
	input wire logic       display_on_q,
	input wire logic       sleep_q,
	input wire logic       drivers_hiz_q,
	input wire logic       pump_run_q,
	input wire logic       pixel_lit_q,
	input wire logic [2:0] page_q,
	input wire logic       scan_down_q,
	input wire logic [5:0] mux_code_q,
	input wire logic [6:0] mux_rows_q,
	input wire logic       ram_wr_q,
	input wire logic [7:0] ram_data_q,
	input wire logic [7:0] common_deselect_level_q,
	input wire logic       deselect_sat_q
);
	logic       pend_q;
	logic [7:0] lead_q;
	logic       cmd;
	logic       single;

	assign cmd    = wr_valid && !cmd_data_select;
	assign single = cmd && !pend_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Lead byte of a two-byte command makes the next command byte its data
	always_ff @(posedge clk) begin
		if (reset) begin
			pend_q <= 1'b0;
			lead_q <= 8'h00;
		end else if (cmd) begin
			pend_q <= !pend_q && (wr_byte inside {8'ha8, 8'had, 8'hd3, 8'hd5, 8'hd9, 8'hda, 8'hdb});
			lead_q <= wr_byte;
		end
	end

	a_host_idle_reset: assert property ($fell(reset) |-> !wr_valid)
		else $error("host offers a byte right after reset");
	a_all_on_set: assert property (single && wr_byte[7:1] == 7'h52 |=> all_on_q == $past(wr_byte[0]))
		else $error("all-on setting does not follow its command");
	a_display_set: assert property (single && wr_byte[7:1] == 7'h57 |=> display_on_q == $past(wr_byte[0]))
		else $error("display on/off does not follow its command");
	a_page_load: assert property (single && wr_byte[7:3] == 5'h16 |=> page_q == $past(wr_byte[2:0]))
		else $error("page address not loaded");
	a_scan_set: assert property (single && wr_byte[7:4] == 4'hc |=> scan_down_q == $past(wr_byte[3]))
		else $error("scan direction does not follow its command");
	a_mux_data: assert property (cmd && pend_q && lead_q == 8'ha8 |=> mux_code_q == $past(wr_byte[5:0]) ##1 mux_rows_q == {1'b0, $past(mux_code_q)} + 7'h01)
		else $error("multiplex ratio data mishandled");
	a_deselect_data: assert property (cmd && pend_q && lead_q == 8'hdb |=> common_deselect_level_q == $past(wr_byte) ##1 deselect_sat_q == ($past(common_deselect_level_q) >= 8'h40))
		else $error("deselect level data mishandled");
	a_sleep_on_off: assert property ($fell(display_on_q) |=> sleep_q && drivers_hiz_q && !pump_run_q)
		else $error("display off did not enter sleep");
	a_ram_write: assert property (wr_valid && cmd_data_select |=> ram_wr_q && ram_data_q == $past(wr_byte))
		else $error("data byte not passed to the RAM port");
	a_pixel_forced: assert property ((display_on_q && all_on_q) [*2] |-> pixel_lit_q)
		else $error("forced pixel not lit");
endmodule

/* File: verif/tb_oled_display_config_decoder.sv */
// Purpose: Self-checking bench for the host end and decoder end joined by the link
// Assumes: Requests go in through the host end only
// Notes:   Rows cover every command form except display off (AE); hand tests cover derived outputs
`timescale 1ns/1ps
`define CHK(n, g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_oled_display_config_decoder;
	import ocd_pkg::*;
	typedef struct {ocd_req_t k; logic [7:0] a; logic [7:0] e;} ocd_row_t;
	logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, ram_bit = 1'b0, req_ready_q, req_refused_q;
	ocd_req_t req_kind = OCD_REQ_ALL_ON;
	logic [7:0] req_arg = 8'h00;
	logic pixel_lit_q, all_on_q, reverse_q, display_on_q, sleep_q, osc_run_q, pump_armed_q;
	logic pump_run_q, ext_supply_q, drivers_hiz_q, scan_down_q, display_clock_tick_q;
	logic pads_alt_q, deselect_sat_q, ram_wr_q, host_on;
	logic [5:0] mux_code_q, offset_q;
	logic [6:0] mux_rows_q;
	logic [2:0] page_q;
	logic [3:0] clk_div_q, osc_trim_q, precharge_q, discharge_q;
	logic signed [7:0] osc_trim_pct_q;
	logic [7:0] common_deselect_level_q, ram_data_q;
	int err_total = 0;
	int cmp_count = 0;
	logic rf, sn;
	int n;
	ocd_row_t rows [23] = '{
		'{OCD_REQ_ALL_ON, 8'h01, 8'h01}, '{OCD_REQ_ALL_ON, 8'h00, 8'h00},
		'{OCD_REQ_REVERSE, 8'h01, 8'h01}, '{OCD_REQ_REVERSE, 8'h00, 8'h00},
		'{OCD_REQ_MUX, 8'hc5, 8'h05}, '{OCD_REQ_MUX, 8'h3f, 8'h3f},
		'{OCD_REQ_PUMP, 8'h00, 8'h00}, '{OCD_REQ_PUMP, 8'h01, 8'h01},
		'{OCD_REQ_OFFSET, 8'hff, 8'h3f}, '{OCD_REQ_OFFSET, 8'h10, 8'h10},
		'{OCD_REQ_CLOCK, 8'h3a, 8'h3a}, '{OCD_REQ_CLOCK, 8'hf0, 8'hf0},
		'{OCD_REQ_PHASE, 8'hf1, 8'hf1}, '{OCD_REQ_PHASE, 8'h1f, 8'h1f},
		'{OCD_REQ_PADS, 8'h02, 8'h00}, '{OCD_REQ_PADS, 8'h12, 8'h01},
		'{OCD_REQ_DESELECT, 8'h20, 8'h20}, '{OCD_REQ_DESELECT, 8'h40, 8'h40},
		'{OCD_REQ_PAGE, 8'h07, 8'h07}, '{OCD_REQ_PAGE, 8'h03, 8'h03},
		'{OCD_REQ_SCAN, 8'h01, 8'h01}, '{OCD_REQ_SCAN, 8'h00, 8'h00},
		'{OCD_REQ_DISPLAY, 8'h01, 8'h01}};

	always #25 clk = ~clk;

	ocd_link_if u_ocd_link_if (.clk(clk));
	ocd_host u_ocd_host (.clk, .reset, .req_valid, .req_kind, .req_arg, .req_ready_q,
		.req_refused_q, .display_on_q(host_on), .link(u_ocd_link_if));
	ocd_decoder u_ocd_decoder (.clk, .reset, .link(u_ocd_link_if), .ram_bit, .pixel_lit_q,
		.all_on_q, .reverse_q, .display_on_q, .sleep_q, .osc_run_q, .pump_armed_q, .pump_run_q,
		.ext_supply_q, .drivers_hiz_q, .mux_code_q, .mux_rows_q, .page_q, .scan_down_q, .offset_q,
		.clk_div_q, .osc_trim_q, .osc_trim_pct_q, .display_clock_tick_q, .precharge_q,
		.discharge_q, .pads_alt_q, .common_deselect_level_q, .deselect_sat_q, .ram_wr_q,
		.ram_data_q);
	ocd_link_chk u_ocd_link_chk (.clk, .reset, .wr_valid(u_ocd_link_if.wr_valid),
		.cmd_data_select(u_ocd_link_if.cmd_data_select), .wr_byte(u_ocd_link_if.wr_byte),
		.all_on_q, .display_on_q, .sleep_q, .drivers_hiz_q, .pump_run_q, .pixel_lit_q, .page_q,
		.scan_down_q, .mux_code_q, .mux_rows_q, .ram_wr_q, .ram_data_q, .common_deselect_level_q,
		.deselect_sat_q);

	function automatic logic [7:0] obs(ocd_req_t k);
		case (k)
			OCD_REQ_ALL_ON: return {7'h00, all_on_q};
			OCD_REQ_REVERSE: return {7'h00, reverse_q};
			OCD_REQ_DISPLAY: return {7'h00, display_on_q};
			OCD_REQ_PAGE: return {5'h00, page_q};
			OCD_REQ_SCAN: return {7'h00, scan_down_q};
			OCD_REQ_MUX: return {2'h0, mux_code_q};
			OCD_REQ_PUMP: return {7'h00, pump_armed_q};
			OCD_REQ_OFFSET: return {2'h0, offset_q};
			OCD_REQ_CLOCK: return {osc_trim_q, clk_div_q};
			OCD_REQ_PHASE: return {discharge_q, precharge_q};
			OCD_REQ_PADS: return {7'h00, pads_alt_q};
			default: return common_deselect_level_q;
		endcase
	endfunction

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Offer one request once ready, then watch four cycles for bytes or refusal
	task automatic send(input ocd_req_t k, input logic [7:0] a);
		int i;
		rf = 1'b0;
		sn = 1'b0;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			#1;
			if (req_ready_q === 1'b1) break;
		end
		if (i == 20) begin
			err_total++;
			stop_test();
		end
		@(posedge clk);
		req_valid <= 1'b1;
		req_kind  <= k;
		req_arg   <= a;
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		for (i = 0; i < 4; i++) begin
			rf |= req_refused_q === 1'b1;
			sn |= u_ocd_link_if.wr_valid === 1'b1;
			@(posedge clk);
			#1;
		end
	endtask

	task automatic px(input logic b);
		@(posedge clk);
		ram_bit <= b;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic chk_defaults();
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		`CHK("flags", {all_on_q, reverse_q, display_on_q, sleep_q, drivers_hiz_q, pump_armed_q, scan_down_q, pads_alt_q}, 8'b0001_1101)
		`CHK("cfg", {mux_code_q, offset_q, page_q, clk_div_q, osc_trim_q, precharge_q, discharge_q, common_deselect_level_q}, {6'h3f, 6'h00, 3'h0, 4'h0, 4'h5, 4'h2, 4'h2, 8'h20})
		`CHK("derived", {mux_rows_q, osc_trim_pct_q, pixel_lit_q}, {7'h40, 8'h00, 1'b0})
		$display("reset test done");
	endtask

	initial begin
		chk_defaults();
		foreach (rows[r]) begin
			send(rows[r].k, rows[r].a);
			`CHK("row", {sn, obs(rows[r].k)}, {1'b1, rows[r].e})
		end
		`CHK("sat pct", {deselect_sat_q, osc_trim_pct_q}, {1'b1, 8'h32})
		`CHK("power on", {sleep_q, osc_run_q, drivers_hiz_q, pump_run_q, ext_supply_q, host_on}, 6'h15)
		$display("row test done");
		send(OCD_REQ_PUMP, 8'h00);
		`CHK("pump while on", {rf, sn}, 2'b10)
		send(OCD_REQ_PHASE, 8'h20);
		`CHK("zero precharge", {rf, sn}, 2'b10)
		send(OCD_REQ_PHASE, 8'h02);
		`CHK("zero discharge", {rf, sn}, 2'b10)
		$display("refusal test done");
		px(1'b1);
		`CHK("pixel normal", pixel_lit_q, 1'b1)
		send(OCD_REQ_REVERSE, 8'h01);
		px(1'b0);
		`CHK("pixel reverse", pixel_lit_q, 1'b1)
		px(1'b1);
		`CHK("pixel reverse off", pixel_lit_q, 1'b0)
		send(OCD_REQ_ALL_ON, 8'h01);
		px(1'b1);
		`CHK("pixel forced", pixel_lit_q, 1'b1)
		$display("pixel test done");
		send(OCD_REQ_CLOCK, 8'h03);
		`CHK("trim pct", osc_trim_pct_q, 8'he7)
		for (n = 0; n < 40 && display_clock_tick_q !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 40) begin
			err_total++;
			stop_test();
		end
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (display_clock_tick_q !== 1'b1 && n < 40);
		`CHK("tick period", n, 4)
		$display("clock test done");
		send(OCD_REQ_DISPLAY, 8'h00);
		`CHK("power off", {sleep_q, osc_run_q, drivers_hiz_q, pump_run_q, ext_supply_q, host_on}, 6'h28)
		`CHK("sleep out", {display_clock_tick_q, pixel_lit_q, all_on_q, page_q}, {2'b00, 1'b1, 3'h3})
		send(OCD_REQ_RAM, 8'h5c);
		`CHK("ram in sleep", ram_data_q, 8'h5c)
		send(OCD_REQ_MUX, 8'h05);
		`CHK("mux rows", mux_rows_q, 7'h06)
		$display("sleep test done");
		@(posedge clk);
		reset <= 1'b1;
		chk_defaults();
		stop_test();
	end
endmodule
